/* File: rtl/aofc_pkg.sv */
`default_nettype none
package aofc_pkg;
  // ************************************************************
  // widths
  // ************************************************************
  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;
  localparam int SAMPLE_W = 16;
  localparam int OFS_W = 8;
  localparam int OFS_FRAC = 3;
  localparam int ACC_FRAC = 16;
  localparam int ACC_W = SAMPLE_W + ACC_FRAC;
  localparam int SHIFT_W = 5;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  localparam int N_AXIS = 3;

  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam logic [IDX_W-1:0] IDX_Z_LP_OFS = 8'h4C;
  localparam logic [IDX_W-1:0] IDX_X_LN_OFS = 8'h4D;
  localparam logic [IDX_W-1:0] IDX_Y_LN_OFS = 8'h4E;
  localparam logic [IDX_W-1:0] IDX_Z_LN_OFS = 8'h4F;
  localparam logic [IDX_W-1:0] IDX_FILT_CFG = 8'h50;
  localparam logic [IDX_W-1:0] IDX_STATUS = 8'h51;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ************************************************************
  // filter configuration fields
  // ************************************************************
  localparam int CFG_DROOP_BIT = 7;
  localparam int CFG_EQ_BIT = 6;
  localparam int CFG_LPF_HI = 5;
  localparam int CFG_LPF_LO = 4;
  localparam int CFG_HPR_BIT = 3;
  localparam int CFG_HPC_HI = 2;
  localparam int CFG_HPC_LO = 0;

  // status fields
  localparam int ST_LOWNOISE = 0;
  localparam int ST_DROOP = 1;
  localparam int ST_EQ = 2;
  localparam int ST_LPF = 3;
  localparam int ST_HPF = 4;

  typedef enum logic [2:0] {
    PM_ULP = 3'h0,
    PM_VLP = 3'h1,
    PM_HS = 3'h2,
    PM_HP = 3'h3,
    PM_LP = 3'h4,
    PM_RBW = 3'h5
  } aofc_pmode_t;

  typedef enum logic [1:0] {
    LPF_OFF = 2'h0,
    LPF_Q4 = 2'h1,
    LPF_Q8 = 2'h2,
    LPF_Q16 = 2'h3
  } aofc_lpf_t;

  localparam logic [2:0] HPC_OFF = 3'h0;
  localparam logic [2:0] HPC_RSVD = 3'h7;
  localparam logic [SHIFT_W-1:0] HPF_K_BASE = 5'h06;
  localparam logic [SHIFT_W-1:0] HPF_K_STEP = 5'h02;
  localparam logic [SHIFT_W-1:0] K_ONE = 5'h01;
  localparam logic [SHIFT_W-1:0] LPF_K_BASE = 5'h00;

  localparam logic [SAMPLE_W-1:0] SAT_MAX = 16'h7FFF;
  localparam logic [SAMPLE_W-1:0] SAT_MIN = 16'h8000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: rtl/aofc_smp_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface aofc_smp_if;
  import aofc_pkg::*;
  logic [SAMPLE_W-1:0] data;
  logic valid;
  modport src (output data, output valid);
  modport dst (input data, input valid);
endinterface
`default_nettype wire

/* File: rtl/aofc_offset_add.sv */
`timescale 1ns/10ps
`default_nettype none
module aofc_offset_add (
  input wire logic [aofc_pkg::SAMPLE_W-1:0] sample_i, // raw sample
  input wire logic [aofc_pkg::OFS_W-1:0] offset_i, // signed offset
  input wire logic valid_i, // sample strobe
  aofc_smp_if.src smp // corrected sample
);
  import aofc_pkg::*;
  localparam int SUM_W = SAMPLE_W + OFS_FRAC + 1;
  logic signed [SUM_W-1:0] sum;
  logic [SAMPLE_W:0] sh;

  // ************************************************************
  // offset in eighths of an lsb, floor then saturate
  // ************************************************************
  always_comb begin
    sum = $signed({sample_i[SAMPLE_W-1], sample_i, {OFS_FRAC{1'b0}}})
      + $signed({{(SUM_W-OFS_W){offset_i[OFS_W-1]}}, offset_i});
    sh = sum[SUM_W-1:OFS_FRAC];
    if (sh[SAMPLE_W] != sh[SAMPLE_W-1]) begin
      smp.data = sh[SAMPLE_W] ? SAT_MIN : SAT_MAX;
    end else begin
      smp.data = sh[SAMPLE_W-1:0];
    end
    smp.valid = valid_i;
  end
endmodule
`default_nettype wire

/* File: rtl/aofc_iir1.sv */
`timescale 1ns/10ps
`default_nettype none
module aofc_iir1 (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic valid_i, // sample strobe
  input wire logic en_i, // filter active
  input wire logic [aofc_pkg::SHIFT_W-1:0] shift_i, // pole as 2^-k
  input wire logic [aofc_pkg::SAMPLE_W-1:0] x_i, // input
  output logic [aofc_pkg::SAMPLE_W-1:0] lp_o, // low-pass result
  output logic [aofc_pkg::SAMPLE_W-1:0] hp_o // high-pass result
);
  import aofc_pkg::*;
  typedef struct packed {
    logic [ACC_W-1:0] acc;
  } aofc_iir_st_t;
  aofc_iir_st_t s, nxt;
  logic signed [ACC_W:0] diff;
  logic signed [ACC_W:0] upd;
  logic [ACC_W-1:0] lp;
  logic [SAMPLE_W:0] hp;

  // ************************************************************
  // one-pole section, coefficient a fixed fraction of the rate
  // ************************************************************
  always_comb begin
    nxt = s;
    diff = $signed({x_i[SAMPLE_W-1], x_i, {ACC_FRAC{1'b0}}})
      - $signed({s.acc[ACC_W-1], s.acc});
    upd = $signed({s.acc[ACC_W-1], s.acc}) + (diff >>> shift_i);
    // while off the state tracks the input so a restart is clean
    lp = en_i ? upd[ACC_W-1:0] : {x_i, {ACC_FRAC{1'b0}}};
    if (valid_i) begin
      nxt.acc = lp;
    end
    lp_o = lp[ACC_W-1:ACC_FRAC];
    hp = {x_i[SAMPLE_W-1], x_i} - {lp_o[SAMPLE_W-1], lp_o};
    if (hp[SAMPLE_W] != hp[SAMPLE_W-1]) begin
      hp_o = hp[SAMPLE_W] ? SAT_MIN : SAT_MAX;
    end else begin
      hp_o = hp[SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= nxt;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/accel_offset_and_filter_config.sv */
`timescale 1ns/10ps
`default_nettype none
module accel_offset_and_filter_config (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [aofc_pkg::AXI_AW-1:0] s_axi_awaddr, // write addr
  input wire logic s_axi_awvalid, // write addr valid
  output logic s_axi_awready, // write addr ready
  input wire logic [aofc_pkg::AXI_DW-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // response valid
  input wire logic s_axi_bready, // response ready
  input wire logic [aofc_pkg::AXI_AW-1:0] s_axi_araddr, // read addr
  input wire logic s_axi_arvalid, // read addr valid
  output logic s_axi_arready, // read addr ready
  output logic [aofc_pkg::AXI_DW-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire aofc_pkg::aofc_pmode_t power_mode_select, // power mode
  input wire logic smp_valid, // input sample strobe
  input wire logic [aofc_pkg::SAMPLE_W-1:0] smp_x, // x sample
  input wire logic [aofc_pkg::SAMPLE_W-1:0] smp_y, // y sample
  input wire logic [aofc_pkg::SAMPLE_W-1:0] smp_z, // z sample
  output logic out_valid, // corrected sample strobe
  output logic [aofc_pkg::SAMPLE_W-1:0] out_x, // x result
  output logic [aofc_pkg::SAMPLE_W-1:0] out_y, // y result
  output logic [aofc_pkg::SAMPLE_W-1:0] out_z, // z result
  output logic droop_comp_en, // droop filter running
  output logic equalizer_en, // equalizer running
  output logic lowpass_en, // low-pass running
  output logic highpass_lowpower_en, // high-pass on low-power path
  output logic highpass_lownoise_en // high-pass on low-noise path
);
  import aofc_pkg::*;

  typedef struct packed {
    logic [7:0] z_lp;
    logic [7:0] x_ln;
    logic [7:0] y_ln;
    logic [7:0] z_ln;
    logic [7:0] cfg;
    logic aw_held;
    logic [AXI_AW-1:0] aw_addr;
    logic w_held;
    logic [7:0] wbyte;
    logic wlane;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rbyte;
    logic [2:0] pmode;
    logic in_v;
    logic [N_AXIS-1:0][SAMPLE_W-1:0] in_s;
    logic out_v;
    logic [N_AXIS-1:0][SAMPLE_W-1:0] out_s;
    logic droop;
    logic eq;
    logic lpf;
    logic hplp;
    logic hpln;
  } aofc_top_st_t;

  aofc_top_st_t s, nxt;
  logic lownoise, eq_on, lpf_on, hpc_ok, hplp_on, hpln_on, hp_on;
  logic [1:0] lpf_sel;
  logic [2:0] hpc;
  logic [SHIFT_W-1:0] lpf_k, hpf_k;
  logic [7:0] status;
  logic [N_AXIS-1:0][OFS_W-1:0] ofs;
  logic [N_AXIS-1:0][SAMPLE_W-1:0] res;
  logic rd_ok, wr_ok;
  logic [7:0] rd_val;

  // ************************************************************
  // mode and filter decode
  // ************************************************************
  always_comb begin
    lownoise = (s.pmode == PM_HP) || (s.pmode == PM_LP)
      || (s.pmode == PM_RBW);
    eq_on = (s.pmode == PM_HP) && !s.cfg[CFG_EQ_BIT];
    lpf_sel = s.cfg[CFG_LPF_HI:CFG_LPF_LO];
    lpf_on = lownoise && s.cfg[CFG_EQ_BIT]
      && (lpf_sel != LPF_OFF);
    lpf_k = LPF_K_BASE + {3'h0, lpf_sel};
    hpc = s.cfg[CFG_HPC_HI:CFG_HPC_LO];
    hpc_ok = (hpc != HPC_OFF) && (hpc != HPC_RSVD);
    hpf_k = HPF_K_BASE
      + SHIFT_W'(HPF_K_STEP * ({2'h0, hpc} - K_ONE));
    hplp_on = hpc_ok && !s.cfg[CFG_HPR_BIT] && !lownoise;
    hpln_on = hpc_ok && s.cfg[CFG_HPR_BIT] && lownoise;
    hp_on = hplp_on || hpln_on;
    // the low-power path carries only the z correction here
    ofs[0] = lownoise ? s.x_ln : REG_RESET;
    ofs[1] = lownoise ? s.y_ln : REG_RESET;
    ofs[2] = lownoise ? s.z_ln : s.z_lp;
    status = REG_RESET;
    status[ST_LOWNOISE] = lownoise;
    status[ST_DROOP] = !s.cfg[CFG_DROOP_BIT];
    status[ST_EQ] = eq_on;
    status[ST_LPF] = lpf_on;
    status[ST_HPF] = hp_on;
  end

  // ************************************************************
  // per-axis datapath
  // ************************************************************
  for (genvar i = 0; i < N_AXIS; i++) begin : g_axis
    aofc_smp_if ofs_if ();
    logic [SAMPLE_W-1:0] lp1, lp2, post_lp, hp;
    aofc_offset_add u_ofs (
      .sample_i(s.in_s[i]),
      .offset_i(ofs[i]),
      .valid_i(s.in_v),
      .smp(ofs_if)
    );
    aofc_iir1 u_lp1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .valid_i(ofs_if.valid),
      .en_i(lpf_on),
      .shift_i(lpf_k),
      .x_i(ofs_if.data),
      .lp_o(lp1),
      .hp_o()
    );
    aofc_iir1 u_lp2 (
      .aclk(aclk),
      .aresetn(aresetn),
      .valid_i(ofs_if.valid),
      .en_i(lpf_on),
      .shift_i(lpf_k),
      .x_i(lp1),
      .lp_o(lp2),
      .hp_o()
    );
    assign post_lp = lpf_on ? lp2 : ofs_if.data;
    aofc_iir1 u_hp (
      .aclk(aclk),
      .aresetn(aresetn),
      .valid_i(ofs_if.valid),
      .en_i(hp_on),
      .shift_i(hpf_k),
      .x_i(post_lp),
      .lp_o(),
      .hp_o(hp)
    );
    assign res[i] = hp_on ? hp : post_lp;
  end

  // ************************************************************
  // register decode
  // ************************************************************
  always_comb begin
    rd_ok = 1'b1;
    rd_val = REG_RESET;
    if (s_axi_araddr[AXI_AW-1:IDX_W+IDX_LSB] != '0) begin
      rd_ok = 1'b0;
    end else if (s_axi_araddr[IDX_W+IDX_LSB-1:IDX_LSB] == IDX_Z_LP_OFS) begin
      rd_val = s.z_lp;
    end else if (s_axi_araddr[IDX_W+IDX_LSB-1:IDX_LSB] == IDX_X_LN_OFS) begin
      rd_val = s.x_ln;
    end else if (s_axi_araddr[IDX_W+IDX_LSB-1:IDX_LSB] == IDX_Y_LN_OFS) begin
      rd_val = s.y_ln;
    end else if (s_axi_araddr[IDX_W+IDX_LSB-1:IDX_LSB] == IDX_Z_LN_OFS) begin
      rd_val = s.z_ln;
    end else if (s_axi_araddr[IDX_W+IDX_LSB-1:IDX_LSB] == IDX_FILT_CFG) begin
      rd_val = s.cfg;
    end else if (s_axi_araddr[IDX_W+IDX_LSB-1:IDX_LSB] == IDX_STATUS) begin
      rd_val = status;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt = s;
    wr_ok = 1'b0;
    // write address and data are taken independently
    if (s_axi_awvalid && s.awready) begin
      nxt.aw_held = 1'b1;
      nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      nxt.w_held = 1'b1;
      nxt.wbyte = s_axi_wdata[7:0];
      nxt.wlane = s_axi_wstrb[0];
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      nxt.aw_held = 1'b0;
      nxt.w_held = 1'b0;
      nxt.bvalid = 1'b1;
      wr_ok = 1'b1;
      if (s.aw_addr[AXI_AW-1:IDX_W+IDX_LSB] != '0) begin
        wr_ok = 1'b0;
      end else if (s.aw_addr[IDX_W+IDX_LSB-1:IDX_LSB] == IDX_Z_LP_OFS) begin
        if (s.wlane) nxt.z_lp = s.wbyte;
      end else if (s.aw_addr[IDX_W+IDX_LSB-1:IDX_LSB] == IDX_X_LN_OFS) begin
        if (s.wlane) nxt.x_ln = s.wbyte;
      end else if (s.aw_addr[IDX_W+IDX_LSB-1:IDX_LSB] == IDX_Y_LN_OFS) begin
        if (s.wlane) nxt.y_ln = s.wbyte;
      end else if (s.aw_addr[IDX_W+IDX_LSB-1:IDX_LSB] == IDX_Z_LN_OFS) begin
        if (s.wlane) nxt.z_ln = s.wbyte;
      end else if (s.aw_addr[IDX_W+IDX_LSB-1:IDX_LSB] == IDX_FILT_CFG) begin
        if (s.wlane) nxt.cfg = s.wbyte;
      end else begin
        wr_ok = 1'b0;
      end
      nxt.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s.bvalid && s_axi_bready) begin
      nxt.bvalid = 1'b0;
    end
    nxt.awready = !nxt.aw_held && !nxt.bvalid;
    nxt.wready = !nxt.w_held && !nxt.bvalid;
    if (s_axi_arvalid && s.arready) begin
      nxt.rvalid = 1'b1;
      nxt.rbyte = rd_val;
      nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rvalid && s_axi_rready) begin
      nxt.rvalid = 1'b0;
    end
    nxt.arready = !nxt.rvalid;
    // sample pipeline: capture, then correct and filter
    nxt.pmode = power_mode_select;
    nxt.in_v = smp_valid;
    if (smp_valid) begin
      nxt.in_s = {smp_z, smp_y, smp_x};
    end
    nxt.out_v = s.in_v;
    if (s.in_v) begin
      nxt.out_s = res;
    end
    nxt.droop = !s.cfg[CFG_DROOP_BIT];
    nxt.eq = eq_on;
    nxt.lpf = lpf_on;
    nxt.hplp = hplp_on;
    nxt.hpln = hpln_on;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= nxt;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = {{(AXI_DW-8){1'b0}}, s.rbyte};
  assign out_valid = s.out_v;
  assign out_x = s.out_s[0];
  assign out_y = s.out_s[1];
  assign out_z = s.out_s[2];
  assign droop_comp_en = s.droop;
  assign equalizer_en = s.eq;
  assign lowpass_en = s.lpf;
  assign highpass_lowpower_en = s.hplp;
  assign highpass_lownoise_en = s.hpln;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence plain_pass_s;
    s.in_v && !lpf_on && !hp_on;
  endsequence

  rst_regs_a: assert property (!$past(aresetn) |->
    s.cfg == REG_RESET && s.z_lp == REG_RESET && s.x_ln == REG_RESET)
    else $error("registers not zero after reset");
  droop_skip_a: assert property (
    $past(aresetn) |-> droop_comp_en == !$past(s.cfg[CFG_DROOP_BIT]))
    else $error("droop enable wrong");
  eq_mode_a: assert property (
    $past(s.pmode == PM_HP && !s.cfg[CFG_EQ_BIT]) |-> equalizer_en)
    else $error("equalizer not running");
  eq_off_a: assert property (equalizer_en |-> $past(s.pmode) == PM_HP)
    else $error("equalizer outside high-performance");
  lpf_gate_a: assert property (
    lowpass_en |-> $past(s.cfg[CFG_EQ_BIT] && lownoise))
    else $error("low-pass without equalizer skip");
  hp_route_a: assert property (
    highpass_lownoise_en |-> $past(s.cfg[CFG_HPR_BIT]) && !highpass_lowpower_en)
    else $error("high-pass route wrong");
  hp_rsvd_a: assert property ($past(hpc == HPC_RSVD) |->
    !highpass_lowpower_en && !highpass_lownoise_en)
    else $error("reserved cutoff enabled high-pass");
  lp_path_a: assert property (plain_pass_s and !lownoise
    |=> out_x == $past(s.in_s[0]) && out_valid)
    else $error("x offset applied on low-power path");
  ofs_scale_a: assert property (plain_pass_s and lownoise
    and s.in_s[1] == '0 and s.y_ln == 8'h08 |=> out_y == 16'h0001)
    else $error("offset scale wrong");
  ofs_sign_a: assert property (plain_pass_s and lownoise
    and s.in_s[0] == '0 and s.x_ln == 8'hF8 |=> out_x == 16'hFFFF)
    else $error("offset sign wrong");
  wr_resp_a: assert property (s.aw_held && s.w_held && !s.bvalid
    |=> s_axi_bvalid && !s_axi_awready ##1 1'b1)
    else $error("write response missing");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid [*1] ##0 !s_axi_arready)
    else $error("read response missing");
endmodule
`default_nettype wire

/* File: verification/accel_offset_and_filter_config_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module accel_offset_and_filter_config_tb_top;
  import aofc_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, smp_valid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, out_valid;
  logic [AXI_DW-1:0] wdata = '0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  aofc_pmode_t pmode = PM_ULP;
  logic [SAMPLE_W-1:0] sx = '0, sy = '0, sz = '0, ox, oy, oz;
  logic dce, eqe, lpe, hpl, hpn;
  int errors = 0;
  int check_count = 0;

  always #5 aclk = ~aclk;

  accel_offset_and_filter_config i_accel_offset_and_filter_config (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .power_mode_select(pmode), .smp_valid(smp_valid),
    .smp_x(sx), .smp_y(sy), .smp_z(sz), .out_valid(out_valid),
    .out_x(ox), .out_y(oy), .out_z(oz), .droop_comp_en(dce),
    .equalizer_en(eqe), .lowpass_en(lpe),
    .highpass_lowpower_en(hpl), .highpass_lownoise_en(hpn)
  );

  // ************************************************************
  // reporting
  // ************************************************************
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: flag got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    if (n > 50) begin
      errors++;
      $display("Error at %0t: wait got %h expected %h", $time, 1'b0, 1'b1);
      close_out;
    end
  endtask

  // ************************************************************
  // bus and sample drivers
  // ************************************************************
  function automatic logic [AXI_AW-1:0] ra(input int i);
    return AXI_AW'(4 * (int'(IDX_Z_LP_OFS) + i));
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [7:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      tick(n);
    end while (!bvalid);
    // bready and rready stay high between transfers
    r = bresp;
  endtask

  task automatic axi_rd(input logic [AXI_AW-1:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
      tick(n);
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(ra(i), d, 4'hF, r);
    cmp_val({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic smp(input logic [15:0] x, y, z);
    int n;
    n = 0;
    sx <= x;
    sy <= y;
    sz <= z;
    smp_valid <= 1'b1;
    @(posedge aclk);
    smp_valid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
      tick(n);
    end while (!out_valid);
  endtask

  function automatic logic [15:0] eo(input logic [15:0] s, input logic [7:0] o);
    int v;
    v = ($signed(s) * 8 + $signed(o)) >>> 3;
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v[15:0];
  endfunction

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 5; i++) begin
      axi_rd(ra(i), d, r);
      cmp_val(d, 32'h00000000);
    end
    cmp_bit(dce, 1'b1);
    cmp_bit(eqe | lpe | hpl | hpn, 1'b0);
    $display("reset test done");
  endtask

  task automatic t_regs;
    logic [7:0] v[5] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h96};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 5; i++) wr(i, v[i]);
    axi_wr(ra(1), 8'h11, 4'h0, r);
    cmp_val({30'h0, r}, {30'h0, RESP_OKAY});
    for (int i = 0; i < 5; i++) begin
      axi_rd(ra(i), d, r);
      cmp_val(d, {24'h0, v[i]});
    end
    axi_wr(12'h400, 8'h11, 4'hF, r);
    cmp_val({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_wr(ra(5), 8'h11, 4'hF, r);
    cmp_val({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(12'h400, d, r);
    cmp_val(d, 32'h00000000);
    cmp_val({30'h0, r}, {30'h0, RESP_SLVERR});
    $display("register test done");
  endtask

  task automatic t_offset;
    logic lown;
    wr(4, 8'hC0);
    wr(0, 8'h7F);
    wr(1, 8'hF0);
    wr(2, 8'h0C);
    wr(3, 8'h80);
    for (int m = 0; m < 6; m++) begin
      lown = (m >= 3);
      pmode <= aofc_pmode_t'(m);
      idle(3);
      smp(16'd100, 16'h7FFF, 16'hFFF0);
      cmp_val(ox, lown ? eo(16'd100, 8'hF0) : 16'd100);
      cmp_val(oy, 16'h7FFF);
      cmp_val(oz, eo(16'hFFF0, lown ? 8'h80 : 8'h7F));
    end
    wr(1, 8'hF8);
    wr(2, 8'h08);
    smp(16'h0000, 16'h0000, 16'h0000);
    cmp_val(ox, 16'hFFFF);
    cmp_val(oy, 16'h0001);
    for (int i = 0; i < 4; i++) wr(i, 8'h00);
    $display("offset test done");
  endtask

  task automatic t_flags;
    logic [7:0] c[8] = '{8'h00, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80,
                         8'h30, 8'hF0};
    logic [31:0] d;
    logic [31:0] e;
    logic [1:0] r;
    for (int m = 0; m < 6; m++) begin
      for (int j = 0; j < 8; j++) begin
        wr(4, c[j]);
        pmode <= aofc_pmode_t'(m);
        idle(3);
        cmp_bit(dce, !c[j][7]);
        cmp_bit(eqe, m == 3 && !c[j][6]);
        cmp_bit(lpe, m >= 3 && c[j][6] && c[j][5:4] != 2'b00);
        axi_rd(ra(5), d, r);
        e = {27'h0, 1'b0, m >= 3 && c[j][6] && c[j][5:4] != 2'b00,
             m == 3 && !c[j][6], !c[j][7], m >= 3};
        cmp_val(d, e);
      end
    end
    $display("filter enable test done");
  endtask

  task automatic t_hpflag;
    logic on;
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 8; k++) begin
        wr(4, {4'hC, r[0], k[2:0]});
        pmode <= r ? PM_HP : PM_ULP;
        idle(3);
        on = (k != 0 && k != 7);
        cmp_bit(hpl, on && r == 0);
        cmp_bit(hpn, on && r == 1);
      end
    end
    $display("high-pass enable test done");
  endtask

  task automatic t_data;
    pmode <= PM_HP;
    wr(4, 8'hC8);
    smp(16'd1000, 16'd1000, 16'd1000);
    cmp_val(ox, 16'd1000);
    wr(4, 8'hC9);
    smp(16'd2000, 16'd2000, 16'd2000);
    cmp_bit($signed(ox) > 16'sd900 && $signed(ox) <= 16'sd1010, 1'b1);
    wr(4, 8'hCF);
    smp(16'd2000, 16'd2000, 16'd2000);
    cmp_val(ox, 16'd2000);
    wr(4, 8'hC1);
    smp(16'd3000, 16'd3000, 16'd3000);
    cmp_val(oy, 16'd3000);
    wr(4, 8'hC0);
    smp(16'd0, 16'd0, 16'd0);
    wr(4, 8'hD0);
    smp(16'd1000, 16'd1000, 16'd1000);
    cmp_bit($signed(ox) < 16'sd1000, 1'b1);
    pmode <= PM_ULP;
    idle(3);
    smp(16'd1000, 16'd1000, 16'd1000);
    cmp_val(oz, 16'd1000);
    $display("data path test done");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_offset();
    t_flags();
    t_hpflag();
    t_data();
    close_out();
  end
endmodule
`default_nettype wire
